// [inc/fpx_defs.svh]
// register map, field positions, reset values and format constants
// Function
// - signaling NaN sets invalid flag, writes quiet NaN
// - quiet NaN writes quiet NaN, flags untouched
// - infinity with real operand gives signed infinity
// - inf-inf, inf/inf, zero*inf are invalid, NaN
// - denormal operands always complete, result written
// - zero divided by zero is invalid, NaN
// - integer conversion overflow is invalid, NaN
// - divide by zero raised, infinity with xored sign
// - overflow when exponent exceeds 127 or 1023
// - default overflow result follows rounding mode
// - overflow handler, else inexact handler, else default
// - overflow handler gets result scaled down by bias
// - tininess after rounding; underflow handler scaled up
// - default underflow needs tiny and inexact, flags
// - inexact enable set traps with rounding details
// - unhandled overflow sets inexact flag first
// - inexact is the only maskable exception
// - true invalid exceptions set cause register bits
// - every exception except masked inexact traps, user or default handler
`ifndef FPX_DEFS_SVH
`define FPX_DEFS_SVH
`define FPX_ADR_STATUS        8'h00
`define FPX_ADR_CONTROL       8'h04
`define FPX_ADR_CAUSE         8'h08
`define FPX_ADR_MASK          8'h0c
`define FPX_INVALID_ACCRUED_FLAG   4
`define FPX_OVERFLOW_ACCRUED_FLAG  3
`define FPX_UNDERFLOW_ACCRUED_FLAG 2
`define FPX_DIVZERO_ACCRUED_FLAG   1
`define FPX_INEXACT_ACCRUED_FLAG   0
`define FPX_INEXACT_ENABLE_BIT     0
`define FPX_USR_OVF_BIT            1
`define FPX_USR_UNF_BIT            2
`define FPX_USR_DVZ_BIT            3
`define FPX_USR_INV_BIT            4
`define FPX_RM_HI                  15
`define FPX_RM_LO                  14
`define FPX_FLAGS_RST         5'h00
`define FPX_CONTROL_RST       32'h0000_0000
`define FPX_SGL_EMAX          13'sd127
`define FPX_DBL_EMAX          13'sd1023
`define FPX_SGL_EMIN          -13'sd126
`define FPX_DBL_EMIN          -13'sd1022
`define FPX_SGL_BIAS_ADJ      13'sd192
`define FPX_DBL_BIAS_ADJ      13'sd1536
`define FPX_SGL_QNAN          64'h0000_0000_7fc0_0000
`define FPX_DBL_QNAN          64'h7ff8_0000_0000_0000
`define FPX_SGL_INF           64'h0000_0000_7f80_0000
`define FPX_DBL_INF           64'h7ff0_0000_0000_0000
`define FPX_SGL_MAXF          64'h0000_0000_7f7f_ffff
`define FPX_DBL_MAXF          64'h7fef_ffff_ffff_ffff
`define FPX_SGL_SIGN          64'h0000_0000_8000_0000
`define FPX_DBL_SIGN          64'h8000_0000_0000_0000
`endif

// [inc/fpx_pkg.sv]
// types shared by the exception unit and its users
package fpx_pkg;
	typedef enum logic [2:0] {FPX_ADD, FPX_SUB, FPX_MUL, FPX_DIV, FPX_CVT}
		fpx_op_t;
	typedef enum logic {FPX_SGL, FPX_DBL} fpx_prec_t;
	typedef enum logic [2:0] {FPX_TR_NONE, FPX_TR_INV, FPX_TR_DVZ,
		FPX_TR_OVF, FPX_TR_UNF, FPX_TR_INX} fpx_trap_t;
	typedef struct packed {
		logic sign;
		logic snan;
		logic qnan;
		logic inf;
		logic zero;
		logic denorm;
	} fpx_opnd_t;
	typedef struct packed {
		fpx_op_t          op;
		fpx_prec_t        prec;
		fpx_opnd_t        a;
		fpx_opnd_t        b;
		logic             cvt_ovf;
		logic             res_sign;
		logic signed [12:0] res_exp;
		logic [63:0]      rnd_bits;
		logic             guard;
		logic             round;
		logic             sticky;
		logic             rounded_up;
	} fpx_req_t;
	typedef struct packed {
		logic [63:0]      value;
		logic             write;
		fpx_trap_t        trap;
		logic             user;
		logic signed [12:0] handler_exp;
		logic [2:0]       grs;
		logic             rounded_up;
	} fpx_rsp_t;
endpackage : fpx_pkg

// [rtl/fpx_exception_unit.sv]
// floating-point exception detection, default results and registers
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "fpx_defs.svh"
module fpx_exception_unit import fpx_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        op_valid_i,
	input  wire fpx_req_t    op_i,
	output logic             rsp_valid_o,
	output fpx_rsp_t         rsp_o,
	output logic             irq_o
);
	logic [4:0]  fp_status_register_reg, fp_status_register_next;
	logic [31:0] fp_control_register_reg, fp_control_register_next;
	logic [4:0]  fp_exception_cause_register_reg;
	logic [4:0]  fp_exception_cause_register_next;
	logic [4:0]  mask_reg, mask_next;
	logic        ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic        rsp_valid_reg, rsp_valid_next;
	fpx_rsp_t    rsp_reg, rsp_next;

	// classification and default results
	logic              dbl, eff_sub, inf_any, real_other;
	logic              inv_inf, zdz, dvz, tiny, lost, ovf;
	logic signed [12:0] emax, emin, adj;
	logic [63:0]       qnan, inf_v, maxf, sgn;
	logic [1:0]        rm;
	logic              u_inv, u_dvz, u_ovf, u_unf, inx_en;
	logic [4:0]        st_set, cause_set;

	always_comb begin
		dbl = (op_i.prec == FPX_DBL);
		emax = dbl ? `FPX_DBL_EMAX : `FPX_SGL_EMAX;
		emin = dbl ? `FPX_DBL_EMIN : `FPX_SGL_EMIN;
		adj = dbl ? `FPX_DBL_BIAS_ADJ : `FPX_SGL_BIAS_ADJ;
		qnan = dbl ? `FPX_DBL_QNAN : `FPX_SGL_QNAN;
		inf_v = dbl ? `FPX_DBL_INF : `FPX_SGL_INF;
		maxf = dbl ? `FPX_DBL_MAXF : `FPX_SGL_MAXF;
		sgn = dbl ? `FPX_DBL_SIGN : `FPX_SGL_SIGN;
		rm = fp_control_register_reg[`FPX_RM_HI:`FPX_RM_LO];
		inx_en = fp_control_register_reg[`FPX_INEXACT_ENABLE_BIT];
		u_inv = fp_control_register_reg[`FPX_USR_INV_BIT];
		u_dvz = fp_control_register_reg[`FPX_USR_DVZ_BIT];
		u_ovf = fp_control_register_reg[`FPX_USR_OVF_BIT];
		u_unf = fp_control_register_reg[`FPX_USR_UNF_BIT];
		// effective subtraction when signs, after op, disagree
		eff_sub = (op_i.op == FPX_SUB) ? (op_i.a.sign == op_i.b.sign)
			: (op_i.a.sign != op_i.b.sign);
		inv_inf = ((op_i.op == FPX_ADD || op_i.op == FPX_SUB)
			&& op_i.a.inf && op_i.b.inf && eff_sub)
			|| (op_i.op == FPX_DIV && op_i.a.inf && op_i.b.inf)
			|| (op_i.op == FPX_MUL && ((op_i.a.zero && op_i.b.inf)
			|| (op_i.a.inf && op_i.b.zero)));
		zdz = (op_i.op == FPX_DIV) && op_i.a.zero && op_i.b.zero;
		dvz = (op_i.op == FPX_DIV) && op_i.b.zero && !op_i.a.zero
			&& !op_i.a.inf;
		inf_any = op_i.a.inf || op_i.b.inf;
		real_other = !(op_i.a.inf && op_i.b.inf);
		ovf = op_i.res_exp > emax;
		// tininess judged on the already rounded exponent
		tiny = op_i.res_exp < emin;
		lost = op_i.guard || op_i.round || op_i.sticky;
	end

	always_comb begin
		rsp_next = '0;
		rsp_next.grs = {op_i.guard, op_i.round, op_i.sticky};
		rsp_next.rounded_up = op_i.rounded_up;
		rsp_next.handler_exp = op_i.res_exp;
		rsp_next.write = 1'b1;
		rsp_next.value = op_i.rnd_bits;
		rsp_next.trap = FPX_TR_NONE;
		st_set = '0;
		cause_set = '0;
		if (op_i.a.snan || op_i.b.snan) begin
			rsp_next.value = qnan;
			rsp_next.trap = FPX_TR_INV;
			rsp_next.user = u_inv;
			// a user handler finishes the result itself
			rsp_next.write = !u_inv;
			cause_set[`FPX_INVALID_ACCRUED_FLAG] = 1'b1;
			st_set[`FPX_INVALID_ACCRUED_FLAG] = !u_inv;
		end else if (op_i.a.qnan || op_i.b.qnan) begin
			rsp_next.value = qnan;
		end else if (inv_inf || zdz
			|| (op_i.op == FPX_CVT && op_i.cvt_ovf)) begin
			rsp_next.value = qnan;
			rsp_next.trap = FPX_TR_INV;
			rsp_next.user = u_inv;
			rsp_next.write = !u_inv;
			cause_set[`FPX_INVALID_ACCRUED_FLAG] = 1'b1;
			st_set[`FPX_INVALID_ACCRUED_FLAG] = !u_inv;
		end else if (dvz) begin
			rsp_next.value = inf_v
				| ((op_i.a.sign ^ op_i.b.sign) ? sgn : '0);
			rsp_next.trap = FPX_TR_DVZ;
			rsp_next.user = u_dvz;
			rsp_next.write = !u_dvz;
			cause_set[`FPX_DIVZERO_ACCRUED_FLAG] = 1'b1;
			st_set[`FPX_DIVZERO_ACCRUED_FLAG] = !u_dvz;
		end else if (inf_any && real_other) begin
			if (op_i.op == FPX_MUL || op_i.op == FPX_DIV)
				rsp_next.value = inf_v
					| ((op_i.a.sign ^ op_i.b.sign) ? sgn : '0);
			else if (op_i.a.inf)
				rsp_next.value = inf_v | (op_i.a.sign ? sgn : '0);
			else
				rsp_next.value = inf_v | ((op_i.b.sign
					^ (op_i.op == FPX_SUB)) ? sgn : '0);
		end else if (ovf) begin
			cause_set[`FPX_OVERFLOW_ACCRUED_FLAG] = 1'b1;
			if (u_ovf) begin
				rsp_next.trap = FPX_TR_OVF;
				rsp_next.user = 1'b1;
				rsp_next.write = 1'b0;
				rsp_next.handler_exp = op_i.res_exp - adj;
			end else begin
				st_set[`FPX_INEXACT_ACCRUED_FLAG] = 1'b1;
				cause_set[`FPX_INEXACT_ACCRUED_FLAG] = 1'b1;
				rsp_next.trap = FPX_TR_INX;
				rsp_next.user = inx_en;
				rsp_next.write = !inx_en;
				if (!inx_en) begin
					st_set[`FPX_OVERFLOW_ACCRUED_FLAG] = 1'b1;
					case (rm)
					2'b00: rsp_next.value = inf_v
						| (op_i.res_sign ? sgn : '0);
					2'b01: rsp_next.value = maxf
						| (op_i.res_sign ? sgn : '0);
					2'b10: rsp_next.value = op_i.res_sign
						? (inf_v | sgn) : maxf;
					2'b11: rsp_next.value = op_i.res_sign
						? (maxf | sgn) : inf_v;
					default: rsp_next.value = inf_v;
					endcase
				end
			end
		end else if (tiny && u_unf) begin
			rsp_next.trap = FPX_TR_UNF;
			rsp_next.user = 1'b1;
			rsp_next.write = 1'b0;
			rsp_next.handler_exp = op_i.res_exp + adj;
			cause_set[`FPX_UNDERFLOW_ACCRUED_FLAG] = 1'b1;
		end else if (tiny && lost) begin
			rsp_next.trap = FPX_TR_UNF;
			cause_set[`FPX_UNDERFLOW_ACCRUED_FLAG] = 1'b1;
			st_set[`FPX_UNDERFLOW_ACCRUED_FLAG] = 1'b1;
		end else if (lost) begin
			// the enable is the only trap mask, and only for inexact; mask_reg masks only irq_o
			if (inx_en) begin
				rsp_next.trap = FPX_TR_INX;
				rsp_next.user = 1'b1;
				rsp_next.write = 1'b0;
				cause_set[`FPX_INEXACT_ACCRUED_FLAG] = 1'b1;
			end else begin
				st_set[`FPX_INEXACT_ACCRUED_FLAG] = 1'b1;
			end
		end
		if (!op_valid_i) begin
			st_set = '0;
			cause_set = '0;
		end
		rsp_valid_next = op_valid_i;
		if (!op_valid_i)
			rsp_next = rsp_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_valid_reg <= 1'b0;
			rsp_reg <= '0;
		end else begin
			rsp_valid_reg <= rsp_valid_next;
			rsp_reg <= rsp_next;
		end
	end

	assign rsp_valid_o = rsp_valid_reg;
	assign rsp_o = rsp_reg;

	// wishbone slave: one wait state, ack for exactly one cycle
	logic        acc, wr, rd_cause;
	logic [31:0] bmask, rdata;

	always_comb begin
		acc = wb_cyc_i && wb_stb_i && !ack_reg;
		wr = ack_reg && wb_we_i;
		rd_cause = ack_reg && !wb_we_i && (wb_adr_i == `FPX_ADR_CAUSE);
		bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		case (wb_adr_i)
		`FPX_ADR_STATUS:  rdata = {27'h0, fp_status_register_reg};
		`FPX_ADR_CONTROL: rdata = fp_control_register_reg;
		`FPX_ADR_CAUSE:   rdata = {27'h0, fp_exception_cause_register_reg};
		`FPX_ADR_MASK:    rdata = {27'h0, mask_reg};
		default:          rdata = 32'h0;
		endcase
		ack_next = acc;
		dat_next = acc ? rdata : dat_reg;
		fp_status_register_next = fp_status_register_reg;
		fp_control_register_next = fp_control_register_reg;
		mask_next = mask_reg;
		if (wr && wb_adr_i == `FPX_ADR_STATUS)
			fp_status_register_next = (fp_status_register_reg
				& ~bmask[4:0]) | (wb_dat_i[4:0] & bmask[4:0]);
		if (wr && wb_adr_i == `FPX_ADR_CONTROL)
			fp_control_register_next = (fp_control_register_reg
				& ~bmask) | (wb_dat_i & bmask);
		if (wr && wb_adr_i == `FPX_ADR_MASK)
			mask_next = (mask_reg & ~bmask[4:0])
				| (wb_dat_i[4:0] & bmask[4:0]);
		// hardware set wins over a software write
		fp_status_register_next = fp_status_register_next | st_set;
		// read clears only the bits software actually saw
		fp_exception_cause_register_next = (fp_exception_cause_register_reg
			& ~(rd_cause ? dat_reg[4:0] : 5'h00)) | cause_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
			fp_status_register_reg <= `FPX_FLAGS_RST;
			fp_control_register_reg <= `FPX_CONTROL_RST;
			fp_exception_cause_register_reg <= `FPX_FLAGS_RST;
			mask_reg <= `FPX_FLAGS_RST;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			fp_status_register_reg <= fp_status_register_next;
			fp_control_register_reg <= fp_control_register_next;
			fp_exception_cause_register_reg <=
				fp_exception_cause_register_next;
			mask_reg <= mask_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_o = |(fp_exception_cause_register_reg & mask_reg);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_snan_in;
		op_valid_i && (op_i.a.snan || op_i.b.snan);
	endsequence
	sequence s_qnan_only;
		op_valid_i && !op_i.a.snan && !op_i.b.snan
			&& (op_i.a.qnan || op_i.b.qnan);
	endsequence
	sequence s_inv_trap;
		rsp_valid_o && rsp_o.trap == FPX_TR_INV;
	endsequence

	a_snan_flag: assert property (s_snan_in and !u_inv |=>
		fp_status_register_reg[`FPX_INVALID_ACCRUED_FLAG]
		&& rsp_o.value == $past(qnan))
		else $error("signaling nan did not flag invalid");
	a_qnan_quiet: assert property (s_qnan_only and !wr |=>
		$stable(fp_status_register_reg) && rsp_o.value == $past(qnan)
		&& rsp_o.trap == FPX_TR_NONE)
		else $error("quiet nan changed status or trapped");
	a_inv_cause: assert property (s_inv_trap |->
		fp_exception_cause_register_reg[`FPX_INVALID_ACCRUED_FLAG])
		else $error("invalid trap without cause bit");
	a_dvz_sign: assert property (op_valid_i && dvz && !op_i.a.snan
		&& !op_i.b.snan && !op_i.a.qnan && !op_i.b.qnan |=>
		rsp_o.trap == FPX_TR_DVZ && rsp_o.value ==
		($past(inf_v) | (($past(op_i.a.sign) ^ $past(op_i.b.sign))
		? $past(sgn) : 64'h0)))
		else $error("divide by zero result or trap wrong");
	a_ovf_scale: assert property (rsp_valid_o && rsp_o.trap == FPX_TR_OVF
		|-> rsp_o.handler_exp == $past(op_i.res_exp) - $past(adj))
		else $error("overflow handler exponent not scaled");
	a_ovf_inexact: assert property (rsp_valid_o
		&& rsp_o.trap == FPX_TR_INX && !rsp_o.user && rsp_o.write
		|-> fp_status_register_reg[`FPX_INEXACT_ACCRUED_FLAG])
		else $error("default overflow without inexact flag");
	a_inx_mask: assert property (op_valid_i && !inx_en && !ovf && !tiny
		&& lost && !inf_any && !op_i.a.snan && !op_i.b.snan
		&& !op_i.a.qnan && !op_i.b.qnan && op_i.op != FPX_CVT
		&& !dvz && !zdz |=> rsp_o.trap == FPX_TR_NONE
		&& rsp_o.value == $past(op_i.rnd_bits))
		else $error("masked inexact was signaled");
	a_unf_default: assert property (rsp_valid_o
		&& rsp_o.trap == FPX_TR_UNF && !rsp_o.user |->
		fp_status_register_reg[`FPX_UNDERFLOW_ACCRUED_FLAG]
		&& rsp_o.write)
		else $error("default underflow without flag");
	a_trap_user: assert property (rsp_valid_o && rsp_o.trap != FPX_TR_NONE
		&& rsp_o.user |-> !rsp_o.write)
		else $error("user handler trap also wrote result");
	a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o)
		else $error("wishbone ack not a single cycle");
endmodule : fpx_exception_unit

// [test/tb_top.sv]
// self-checking bench for the floating-point exception unit
`timescale 1ns/100ps
`include "fpx_defs.svh"
module tb_top import fpx_pkg::*;;
	logic        clk, rst, cyc, stb, we, op_valid, ack, rsp_valid, irq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	fpx_req_t    r, op;
	fpx_rsp_t    rsp;
	integer      n_fail, total_checks, seed, cycles, i, k;

	fpx_exception_unit dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.op_valid_i(op_valid), .op_i(op), .rsp_valid_o(rsp_valid),
		.rsp_o(rsp), .irq_o(irq));

	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// classic single cycle; waits for ack, only the bench timeout ends it
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (ack !== 1'b1);
		// ack is due one cycle after the request is taken
		chk(64'(n), 64'h2);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk({32'h0, q}, {32'h0, exp});
	endtask : rd

	task run(input fpx_req_t x);
		@(posedge clk);
		op_valid <= 1'b1;
		op <= x;
		@(posedge clk);
		op_valid <= 1'b0;
		@(posedge clk);
		chk({63'h0, rsp_valid}, 64'h1);
	endtask : run

	// status is writable, cause clears on read
	task clr(input logic [31:0] ctl);
		wb(1'b1, `FPX_ADR_STATUS, 32'h0);
		wb(1'b0, `FPX_ADR_CAUSE, 32'h0);
		wb(1'b1, `FPX_ADR_CONTROL, ctl);
	endtask : clr

	function automatic fpx_req_t base(input logic p);
		fpx_req_t b;
		b = '0;
		b.prec = fpx_prec_t'(p);
		b.rnd_bits = p ? 64'h3ff8_0000_0000_0001 : 64'h0000_0000_3fc0_0001;
		return b;
	endfunction : base

	function automatic logic [63:0] ovf_val(input logic p, input logic s,
		input logic [1:0] rm);
		logic [63:0] inf, mx, sg;
		inf = p ? `FPX_DBL_INF : `FPX_SGL_INF;
		mx = p ? `FPX_DBL_MAXF : `FPX_SGL_MAXF;
		sg = s ? (p ? `FPX_DBL_SIGN : `FPX_SGL_SIGN) : 64'h0;
		case (rm)
			2'd0: ovf_val = inf | sg;
			2'd1: ovf_val = mx | sg;
			2'd2: ovf_val = s ? (inf | sg) : mx;
			default: ovf_val = s ? (mx | sg) : inf;
		endcase
	endfunction : ovf_val

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles > 20000) begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	end

	initial begin
		{rst, cyc, stb, we, op_valid, adr, wdat} = '0;
		rst = 1'b1;
		sel = 4'hf;
		op = '0;
		n_fail = 0;
		total_checks = 0;
		cycles = 0;
		seed = 22799;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
		wb(1'b1, 8'h10, 32'hffff_ffff);
		rd(8'h10, 32'h0);
		wb(1'b1, `FPX_ADR_CONTROL, 32'h0000_c01f);
		rd(`FPX_ADR_CONTROL, 32'h0000_c01f);
		$display("test regs done");
		// invalid cases: nan, inf-inf, inf/inf, 0*inf, 0/0, cvt
		for (k = 0; k < 6; k++) begin
			clr(32'h0);
			r = base(1'b0);
			case (k)
				0: r.a.snan = 1'b1;
				1: begin r.a.inf = 1'b1; r.b.inf = 1'b1; r.b.sign = 1'b1; end
				2: begin r.op = FPX_DIV; r.a.inf = 1'b1; r.b.inf = 1'b1; end
				3: begin r.op = FPX_MUL; r.a.zero = 1'b1; r.b.inf = 1'b1; end
				4: begin r.op = FPX_DIV; r.a.zero = 1'b1; r.b.zero = 1'b1; end
				default: begin r.op = FPX_CVT; r.cvt_ovf = 1'b1; end
			endcase
			run(r);
			chk(rsp.value, `FPX_SGL_QNAN);
			chk({61'h0, rsp.trap}, {61'h0, FPX_TR_INV});
			rd(`FPX_ADR_STATUS, 32'h10);
		end
		r = base(1'b1);
		r.b.qnan = 1'b1;
		clr(32'h0);
		run(r);
		chk(rsp.value, `FPX_DBL_QNAN);
		rd(`FPX_ADR_STATUS, 32'h0);
		clr(32'h10);
		r.a.snan = 1'b1;
		run(r);
		chk({63'h0, rsp.write}, 64'h0);
		chk({63'h0, rsp.user}, 64'h1);
		rd(`FPX_ADR_STATUS, 32'h0);
		clr(32'h0);
		$display("test invalid done");
		for (k = 0; k < 4; k++) begin
			r = base(1'b0);
			r.op = fpx_op_t'(k);
			r.a.inf = 1'b1;
			r.b.sign = 1'b1;
			run(r);
			chk(rsp.value, k >= 2 ? 64'hffff_ffff_ff80_0000 & `FPX_SGL_INF
				| `FPX_SGL_SIGN : `FPX_SGL_INF);
		end
		r = base(1'b1);
		r.op = FPX_DIV;
		r.a.sign = 1'b1;
		r.b.zero = 1'b1;
		r.b.sign = 1'b1;
		run(r);
		chk(rsp.value, `FPX_DBL_INF);
		chk({61'h0, rsp.trap}, {61'h0, FPX_TR_DVZ});
		r.a.denorm = 1'b1;
		r.b = '0;
		run(r);
		chk({63'h0, rsp.write}, 64'h1);
		chk(rsp.value, r.rnd_bits);
		$display("test inf done");
		for (k = 0; k < 8; k++) begin
			clr({16'h0, 16'(k >> 1) << 14});
			r = base(k[1]);
			r.res_sign = k[0];
			r.res_exp = k[1] ? 13'sd1024 : 13'sd128;
			run(r);
			chk(rsp.value, ovf_val(k[1], k[0], 2'(k >> 1)));
			rd(`FPX_ADR_STATUS, 32'h09);
		end
		clr(32'h0);
		r = base(1'b0);
		r.res_exp = 13'sd127;
		run(r);
		chk(rsp.value, r.rnd_bits);
		rd(`FPX_ADR_STATUS, 32'h0);
		clr(32'h2);
		r = base(1'b1);
		r.res_exp = 13'sd1030;
		run(r);
		chk({60'h0, rsp.trap, rsp.user},
			{60'h0, FPX_TR_OVF, 1'b1});
		chk(64'(rsp.handler_exp), 64'(-13'sd506));
		clr(32'h1);
		run(r);
		chk({60'h0, rsp.trap, rsp.user},
			{60'h0, FPX_TR_INX, 1'b1});
		$display("test overflow done");
		clr(32'h0);
		r = base(1'b0);
		r.res_exp = -13'sd127;
		r.sticky = 1'b1;
		run(r);
		chk(rsp.value, r.rnd_bits);
		rd(`FPX_ADR_STATUS, 32'h04);
		chk({63'h0, q[2]}, 64'h1);
		clr(32'h4);
		run(r);
		chk({60'h0, rsp.trap, rsp.user},
			{60'h0, FPX_TR_UNF, 1'b1});
		chk(64'(rsp.handler_exp), 64'(13'sd65));
		clr(32'h0);
		r = base(1'b1);
		r.guard = 1'b1;
		run(r);
		chk({61'h0, rsp.trap}, {61'h0, FPX_TR_NONE});
		chk(rsp.value, r.rnd_bits);
		rd(`FPX_ADR_STATUS, 32'h01);
		clr(32'h1);
		r.guard = 1'b1;
		r.sticky = 1'b1;
		r.rounded_up = 1'b1;
		run(r);
		chk({56'h0, rsp.trap, rsp.write, rsp.grs, rsp.rounded_up},
			{56'h0, FPX_TR_INX, 1'b0, 3'b101, 1'b1});
		$display("test under inexact done");
		clr(32'h0);
		wb(1'b1, `FPX_ADR_MASK, 32'h0);
		r = base(1'b0);
		r.a.snan = 1'b1;
		run(r);
		@(posedge clk);
		chk({63'h0, irq}, 64'h0);
		wb(1'b1, `FPX_ADR_MASK, 32'h1f);
		repeat (2) @(posedge clk);
		chk({63'h0, irq}, 64'h1);
		wb(1'b0, `FPX_ADR_CAUSE, 32'h0);
		chk({63'h0, q[4]}, 64'h1);
		repeat (2) @(posedge clk);
		chk({63'h0, irq}, 64'h0);
		$display("test irq done");
		clr(32'h0);
		for (i = 0; i < 30; i++) begin
			r = base(1'($random(seed)));
			r.op = fpx_op_t'(3'($random(seed)) % 4);
			r.res_sign = 1'($random(seed));
			r.res_exp = 13'($random(seed) % 100);
			r.rnd_bits = {r.prec ? 32'($random(seed)) : 32'h0,
				32'($random(seed))};
			run(r);
			chk({61'h0, rsp.trap}, {61'h0, FPX_TR_NONE});
			chk({63'h0, rsp.write}, 64'h1);
			chk(rsp.value, r.rnd_bits);
		end
		$display("test random done");
		give_verdict;
	end
endmodule : tb_top
